/* rtl/ats_pkg.sv */
`default_nettype none
package ats_pkg;
  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_SEL = 8'h08;
  localparam logic [7:0] ADDR_OE = 8'h0C;
  localparam logic [7:0] ADDR_SCAN_IVL = 8'h10;
  localparam logic [7:0] ADDR_SAMP_IVL = 8'h14;
  localparam logic [7:0] ADDR_PRE_CNT = 8'h18;
  localparam logic [7:0] ADDR_POST_CNT = 8'h1C;
  localparam logic [7:0] ADDR_CONV_CNT = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  // command bits (write-only, self-clearing)
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_STROBE_BIT = 2;
  // reset values
  localparam logic [7:0] CFG_RST = 8'h2C;
  localparam logic [15:0] CNT_RST = 16'h0001;
  // pins
  localparam int NPIN = 10;
  localparam int PIN_START = 0;
  localparam int PIN_POST = 1;
  localparam int PIN_CONV = 2;
  localparam int PIN_SCAN = 7;
  localparam logic [9:0] OUT_CAPABLE = 10'h087;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int MON_MIN_NS = 50;
  localparam int MON_CYC = (MON_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_SLOW_NS = 10000;
  localparam int STB_FAST_NS = 1200;
  localparam int STB_SLOW_HALF = STB_SLOW_NS / CLK_NS / 2;
  localparam int STB_FAST_HALF = STB_FAST_NS / CLK_NS / 2;
  localparam int STB_PULSES = 8;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic stb_fast;
    logic stb_burst;
    logic stb_level;
    logic scan_lvl_mon;
    logic int_conv;
    logic int_scan;
    logic sw_gate;
    logic pretrig;
  } ats_cfg_t;
  // pol: [0] start, [1] post, [2] scan, [3] conv, [4] gate; 1 = falling/low
  typedef struct packed {
    logic [5:0] rsv;
    logic gate_lvl;
    logic [4:0] pol;
    logic [3:0] gate;
    logic [3:0] conv;
    logic [3:0] scan;
    logic [3:0] post;
    logic [3:0] start;
  } ats_sel_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRE = 3'b010,
    ST_POST = 3'b100
  } ats_state_t;
endpackage : ats_pkg
`default_nettype wire

/* rtl/ats_sequencer.sv */
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - strobe gives one pulse or burst of eight
// - single mode strobe follows software level
// - burst timed by 10 or 1.2 us clock
// - start trigger edge from any pin starts acquisition
// - start monitor pulses for actual start event
// - all pin drivers off after reset
// - posttrigger edge begins posttrigger phase
// - pretrigger count first, then reload posttrigger count
// - fixed scans after posttrigger, then stop
// - posttrigger monitor pulses on accepted event
// - scan start edge begins scan and sample counter
// - scan monitor is pulse or busy level
// - conversions blocked until scan start
// - internal scan counter runs during acquisition
// - scan starts only inside acquisition, gateable
// - conversion edge starts one conversion
// - conversion monitor active-low copy of applied pulse
// - sample counter reloads per conversion and scan
// - conversions outside acquisition suppressed
// - scan gate level masks, edges toggle
// - gate changes act at next scan start
// - each pin driver enabled separately by software
module ats_sequencer
  import ats_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic external_strobe_out
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic pin_edge(input logic [NPIN-1:0] cur, input logic [NPIN-1:0] prv,
                                    input logic [3:0] idx, input logic pol);
    logic ok;
    ok = (idx < 4'(NPIN));
    return ok & ((cur[idx] ^ pol) & ~(prv[idx] ^ pol));
  endfunction : pin_edge
  function automatic logic pin_lvl(input logic [NPIN-1:0] cur, input logic [3:0] idx,
                                   input logic pol);
    return (idx < 4'(NPIN)) & (cur[idx] ^ pol);
  endfunction : pin_lvl

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  ats_cfg_t cfg_ff;
  ats_sel_t sel_ff;
  logic [NPIN-1:0] oe_reg_ff;
  logic [15:0] scan_ivl_ff, samp_ivl_ff, pre_cnt_ff, post_cnt_ff, conv_cnt_ff;
  logic [2:0] cmd_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic [NPIN-1:0] sync1_ff, sync2_ff, prev_ff, pin_out_ff, pin_oe_ff;
  ats_state_t st_ff, nxt_st;
  logic [15:0] scan_cnt_ff, siv_ff, smp_ff, conv_left_ff;
  logic pre_done_ff, scan_busy_ff, gate_tgl_ff;
  logic [1:0] mon_ff [4];
  logic stb_ff, stb_run_ff;
  logic [8:0] stb_cnt_ff;
  logic [4:0] stb_half_ff;

  logic wr_en, active, start_evt, post_evt, scan_raw, scan_evt, conv_raw, conv_evt;
  logic gated, scan_end;
  logic [3:0] mon_evt;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pin_out = pin_out_ff;
  assign pin_oe = pin_oe_ff;
  assign external_strobe_out = stb_ff;

  // ------------------------------------------------------------
  // apb slave: one access cycle, data prepared in setup
  // ------------------------------------------------------------
  assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  always_comb begin
    nxt_err = 1'b0;
    nxt_rdata = 32'h0000_0000;
    case (paddr)
      ADDR_CMD: nxt_rdata = 32'h0000_0000;
      ADDR_CFG: nxt_rdata = {24'h00_0000, cfg_ff};
      ADDR_SEL: nxt_rdata = sel_ff;
      ADDR_OE: nxt_rdata = {22'h00_0000, oe_reg_ff};
      ADDR_SCAN_IVL: nxt_rdata = {16'h0000, scan_ivl_ff};
      ADDR_SAMP_IVL: nxt_rdata = {16'h0000, samp_ivl_ff};
      ADDR_PRE_CNT: nxt_rdata = {16'h0000, pre_cnt_ff};
      ADDR_POST_CNT: nxt_rdata = {16'h0000, post_cnt_ff};
      ADDR_CONV_CNT: nxt_rdata = {16'h0000, conv_cnt_ff};
      ADDR_STATUS: nxt_rdata = {scan_cnt_ff, 10'h000, gated, scan_busy_ff, pre_done_ff, st_ff};
      default: nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & nxt_err;
      prdata_ff <= (psel & ~penable & ~pwrite) ? nxt_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= CFG_RST;
      sel_ff <= '0;
      oe_reg_ff <= '0;
      scan_ivl_ff <= CNT_RST;
      samp_ivl_ff <= CNT_RST;
      pre_cnt_ff <= CNT_RST;
      post_cnt_ff <= CNT_RST;
      conv_cnt_ff <= CNT_RST;
      cmd_ff <= 3'h0;
    end else begin
      cmd_ff <= (wr_en && paddr == ADDR_CMD) ? pwdata[2:0] : 3'h0;
      if (wr_en) begin
        case (paddr)
          ADDR_CFG: cfg_ff <= pwdata[7:0];
          ADDR_SEL: sel_ff <= {6'h00, pwdata[25:0]};
          ADDR_OE: oe_reg_ff <= pwdata[NPIN-1:0];
          ADDR_SCAN_IVL: scan_ivl_ff <= pwdata[15:0];
          ADDR_SAMP_IVL: samp_ivl_ff <= pwdata[15:0];
          ADDR_PRE_CNT: pre_cnt_ff <= pwdata[15:0];
          ADDR_POST_CNT: post_cnt_ff <= pwdata[15:0];
          ADDR_CONV_CNT: conv_cnt_ff <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // pin synchronizers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff <= '0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // ------------------------------------------------------------
  // event qualification
  // ------------------------------------------------------------
  always_comb begin
    active = (st_ff != ST_IDLE);
    // software start or pin edge, only from idle
    start_evt = (st_ff == ST_IDLE) & (cmd_ff[CMD_START_BIT] |
                pin_edge(sync2_ff, prev_ff, sel_ff.start, sel_ff.pol[0]));
    // posttrigger ignored until the pretrigger count ran out
    post_evt = (st_ff == ST_PRE) & pre_done_ff &
               pin_edge(sync2_ff, prev_ff, sel_ff.post, sel_ff.pol[1]);
    gated = cfg_ff.sw_gate | (sel_ff.gate_lvl ?
            pin_lvl(sync2_ff, sel_ff.gate, sel_ff.pol[4]) : gate_tgl_ff);
    scan_raw = cfg_ff.int_scan ? (active & (siv_ff == 16'h0000)) :
               pin_edge(sync2_ff, prev_ff, sel_ff.scan, sel_ff.pol[2]);
    // gate sampled only here, so a running scan is never cut
    scan_evt = scan_raw & active & ~gated & ~scan_busy_ff &
               ~(st_ff == ST_POST && scan_cnt_ff == 16'h0000);
    conv_raw = cfg_ff.int_conv ? (smp_ff == 16'h0000) :
               pin_edge(sync2_ff, prev_ff, sel_ff.conv, sel_ff.pol[3]);
    conv_evt = conv_raw & scan_busy_ff & active;
    scan_end = conv_evt & (conv_left_ff <= 16'h0001);
    mon_evt = {conv_evt, scan_evt, post_evt, start_evt};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_tgl_ff <= 1'b0;
    end else if (!sel_ff.gate_lvl &&
                 pin_edge(sync2_ff, prev_ff, sel_ff.gate, sel_ff.pol[4])) begin
      gate_tgl_ff <= ~gate_tgl_ff;
    end
  end

  // ------------------------------------------------------------
  // acquisition state and scan counter
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (start_evt) nxt_st = cfg_ff.pretrig ? ST_PRE : ST_POST;
      ST_PRE: if (cmd_ff[CMD_STOP_BIT]) nxt_st = ST_IDLE;
              else if (post_evt) nxt_st = ST_POST;
      ST_POST: if (cmd_ff[CMD_STOP_BIT] || (scan_cnt_ff == 16'h0000 && !scan_busy_ff))
                 nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      scan_cnt_ff <= 16'h0000;
      pre_done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (start_evt) begin
        pre_done_ff <= ~cfg_ff.pretrig | (pre_cnt_ff == 16'h0000);
        scan_cnt_ff <= (cfg_ff.pretrig && pre_cnt_ff != 16'h0000) ? pre_cnt_ff : post_cnt_ff;
      end else if (scan_evt && scan_cnt_ff != 16'h0000 && !(st_ff == ST_PRE && pre_done_ff)) begin
        if (st_ff == ST_PRE && scan_cnt_ff == 16'h0001) begin
          scan_cnt_ff <= post_cnt_ff;
          pre_done_ff <= 1'b1;
        end else begin
          scan_cnt_ff <= scan_cnt_ff - 16'h0001;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // scan interval, sample interval, scan progress
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      siv_ff <= CNT_RST;
    end else if (!active || siv_ff == 16'h0000) begin
      siv_ff <= scan_ivl_ff;
    end else begin
      siv_ff <= siv_ff - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_ff <= CNT_RST;
    end else if (!scan_busy_ff || scan_end || smp_ff == 16'h0000) begin
      smp_ff <= samp_ivl_ff;
    end else begin
      smp_ff <= smp_ff - 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_busy_ff <= 1'b0;
      conv_left_ff <= 16'h0000;
    end else if (!active || nxt_st == ST_IDLE) begin
      scan_busy_ff <= 1'b0;
    end else if (scan_evt) begin
      scan_busy_ff <= 1'b1;
      conv_left_ff <= conv_cnt_ff;
    end else if (conv_evt) begin
      conv_left_ff <= conv_left_ff - 16'h0001;
      if (scan_end) scan_busy_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // monitor pulses and pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) mon_ff[i] <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (mon_evt[i]) mon_ff[i] <= 2'(MON_CYC);
        else if (mon_ff[i] != 2'h0) mon_ff[i] <= mon_ff[i] - 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_ff <= '0;
      pin_oe_ff <= '0;
    end else begin
      pin_oe_ff <= oe_reg_ff & OUT_CAPABLE;
      pin_out_ff <= '0;
      pin_out_ff[PIN_START] <= (mon_ff[0] != 2'h0);
      pin_out_ff[PIN_POST] <= (mon_ff[1] != 2'h0);
      pin_out_ff[PIN_SCAN] <= cfg_ff.scan_lvl_mon ? scan_busy_ff
                                                  : (mon_ff[2] != 2'h0);
      pin_out_ff[PIN_CONV] <= (mon_ff[3] == 2'h0);
    end
  end

  // ------------------------------------------------------------
  // external strobe (active low)
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_ff <= 1'b1;
      stb_run_ff <= 1'b0;
      stb_cnt_ff <= 9'h000;
      stb_half_ff <= 5'h00;
    end else if (!stb_run_ff) begin
      stb_ff <= cfg_ff.stb_burst ? 1'b1 : cfg_ff.stb_level;
      if (cfg_ff.stb_burst && cmd_ff[CMD_STROBE_BIT]) begin
        stb_run_ff <= 1'b1;
        stb_ff <= 1'b0;
        stb_half_ff <= 5'(2 * STB_PULSES - 1);
        stb_cnt_ff <= cfg_ff.stb_fast ? 9'(STB_FAST_HALF - 1) : 9'(STB_SLOW_HALF - 1);
      end
    end else if (stb_cnt_ff != 9'h000) begin
      stb_cnt_ff <= stb_cnt_ff - 9'h001;
    end else if (stb_half_ff == 5'h00) begin
      stb_run_ff <= 1'b0;
      stb_ff <= 1'b1;
    end else begin
      stb_ff <= ~stb_ff;
      stb_half_ff <= stb_half_ff - 5'h01;
      stb_cnt_ff <= cfg_ff.stb_fast ? 9'(STB_FAST_HALF - 1) : 9'(STB_SLOW_HALF - 1);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start_mon;
    start_evt |-> ##2 pin_out_ff[PIN_START] [*3];
  endproperty
  a_start_mon: assert property (p_start_mon) else $error("start monitor pulse wrong");

  property p_conv_mon;
    conv_evt |-> ##2 !pin_out_ff[PIN_CONV] [*3];
  endproperty
  a_conv_mon: assert property (p_conv_mon) else $error("convert monitor pulse wrong");

  property p_post_ignored;
    (st_ff == ST_PRE && !pre_done_ff && !cmd_ff[CMD_STOP_BIT]) |=> st_ff == ST_PRE;
  endproperty
  a_post_ignored: assert property (p_post_ignored) else $error("posttrigger taken early");

  property p_post_stop;
    (st_ff == ST_POST && scan_cnt_ff == 16'h0000 && !scan_busy_ff) |=> st_ff == ST_IDLE;
  endproperty
  a_post_stop: assert property (p_post_stop) else $error("acquisition did not stop");

  property p_conv_in_scan;
    (!scan_busy_ff || st_ff == ST_IDLE) && mon_ff[3] == 2'h0 |=> mon_ff[3] == 2'h0;
  endproperty
  a_conv_in_scan: assert property (p_conv_in_scan) else $error("conversion outside scan");

  property p_scan_in_acq;
    scan_evt && !cmd_ff[CMD_STOP_BIT] |=> scan_busy_ff && $past(st_ff) != ST_IDLE;
  endproperty
  a_scan_in_acq: assert property (p_scan_in_acq) else $error("scan outside acquisition");

  property p_gate_blocks;
    gated && !scan_busy_ff |=> !scan_busy_ff;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("gated scan started");

  property p_strobe_level;
    !stb_run_ff && !cfg_ff.stb_burst |=> stb_ff == $past(cfg_ff.stb_level) || stb_run_ff;
  endproperty
  a_strobe_level: assert property (p_strobe_level) else $error("strobe not following level");

  property p_oe_capable;
    (pin_oe_ff & ~OUT_CAPABLE) == '0;
  endproperty
  a_oe_capable: assert property (p_oe_capable) else $error("driver on input-only pin");
endmodule : ats_sequencer
`default_nettype wire

/* verif/ats_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ats_pin_model
  import ats_pkg::*;
(
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe,
  input wire logic [NPIN-1:0] ext_lvl,
  output logic [NPIN-1:0] pin_in
);
  // ----------------------------------------
  // wire resolution
  // ----------------------------------------
  // released pins take the instruments' level, held in ext_lvl
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule : ats_pin_model
`default_nettype wire

/* verif/acquisition_trigger_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acquisition_trigger_sequencer_tb;
  import ats_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, external_strobe_out;
  logic [NPIN-1:0] pin_in, pin_out, pin_oe, po_q;
  logic [NPIN-1:0] ext_lvl = '0;
  logic stb_q = 1;
  int fails = 0, n_checks = 0;
  int n_start = 0, n_post = 0, n_scan = 0, n_conv = 0, n_stb = 0;
  int run0 = 0, runc = 0, runs = 0, w0 = 0, wc = 0, ws = 0, k = 0, run7 = 0, w7 = 0;
  always #10 pclk = ~pclk;
  ats_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .external_strobe_out(external_strobe_out));
  ats_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  // ----------------------------------------
  // monitor pulse counts and widths
  // ----------------------------------------
  always @(posedge pclk) begin
    po_q <= pin_out;
    stb_q <= external_strobe_out;
    if (pin_out[0] && !po_q[0]) n_start++;
    if (pin_out[1] && !po_q[1]) n_post++;
    if (pin_out[7] && !po_q[7]) n_scan++;
    if (!pin_out[2] && po_q[2]) n_conv++;
    if (!external_strobe_out && stb_q) n_stb++;
    run0 <= pin_out[0] ? run0 + 1 : 0;
    runc <= !pin_out[2] ? runc + 1 : 0;
    runs <= !external_strobe_out ? runs + 1 : 0;
    run7 <= pin_out[7] ? run7 + 1 : 0;
    if (!pin_out[7] && po_q[7]) w7 <= run7;
    if (!pin_out[0] && po_q[0]) w0 <= run0;
    if (pin_out[2] && !po_q[2]) wc <= runc;
    if (external_strobe_out && !stb_q) ws <= runs;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fails++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // levels held 3 cycles so the synchronizer sees each one
  task automatic pulse(input int p);
    ext_lvl[p] <= 1'b1;
    cyc(3);
    ext_lvl[p] <= 1'b0;
    cyc(3);
  endtask : pulse
  task automatic wait_bit(input int b, input logic v);
    int i;
    for (i = 0; i < 300; i++) begin
      apb(1'b0, ADDR_STATUS, 32'h0000_0000);
      if (rd[b] === v) break;
    end
    if (i == 300) begin
      fails++;
      final_report();
    end
  endtask : wait_bit
  task automatic setup(input logic [31:0] cfg, input logic [31:0] sel, input logic [15:0] post);
    wr(ADDR_CFG, cfg);
    wr(ADDR_SEL, sel);
    wr(ADDR_POST_CNT, {16'h0000, post});
  endtask : setup
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(5);
    presetn <= 1'b1;
    cyc(2);
    `CHK(pin_oe, 10'h000)
    `CHK(external_strobe_out, 1'b1)
    apb(1'b0, ADDR_CFG, 32'h0000_0000);
    `CHK(rd, 32'h0000_002C)
    apb(1'b0, 8'h30, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    wr(ADDR_OE, 32'h0000_03FF);
    cyc(2);
    `CHK(pin_oe, 10'h087)
    $display("test reset done");
    wr(ADDR_CFG, 32'h0000_000C);
    cyc(2);
    `CHK(external_strobe_out, 1'b0)
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_CFG, f ? 32'h0000_00EC : 32'h0000_006C);
      k = n_stb;
      wr(ADDR_CMD, 32'h0000_0004);
      cyc(16 * (f ? STB_FAST_HALF : STB_SLOW_HALF) + 20);
      `CHK(n_stb - k, 8)
      `CHK(ws, f ? STB_FAST_HALF : STB_SLOW_HALF)
      `CHK(external_strobe_out, 1'b1)
    end
    $display("test strobe done");
    wr(ADDR_SCAN_IVL, 32'h0000_0004);
    wr(ADDR_SAMP_IVL, 32'h0000_0003);
    wr(ADDR_CONV_CNT, 32'h0000_0002);
    setup(32'h0000_002C, 32'h000F_FFF5, 16'h0002);
    k = n_conv + 100 * n_scan;
    pulse(5);
    wait_bit(0, 1'b1);
    `CHK(n_start, 1)
    `CHK(w0 >= 3 && w0 <= 5, 1'b1)
    `CHK(n_conv + 100 * n_scan - k, 204)
    `CHK(wc >= 3 && wc <= 5, 1'b1)
    $display("test posttriggered done");
    wr(ADDR_PRE_CNT, 32'h0000_0003);
    setup(32'h0000_002D, 32'h000F_FF6F, 16'h0001);
    wr(ADDR_CMD, 32'h0000_0001);
    pulse(6);
    cyc(4);
    `CHK(n_post, 0)
    wait_bit(3, 1'b1);
    pulse(6);
    cyc(4);
    `CHK(n_post, 1)
    wait_bit(0, 1'b1);
    `CHK(n_start, 2)
    $display("test pretriggered done");
    setup(32'h0000_0024, 32'h000F_8FFF, 16'h0001);
    k = n_conv;
    pulse(8);
    cyc(6);
    `CHK(n_conv - k, 0)
    wr(ADDR_CMD, 32'h0000_0001);
    wait_bit(4, 1'b1);
    pulse(8);
    pulse(8);
    wait_bit(0, 1'b1);
    `CHK(n_conv - k, 2)
    $display("test external conversion done");
    setup(32'h0000_002C, 32'h0209_FFFF, 16'h0002);
    ext_lvl[9] <= 1'b1;
    k = n_scan;
    wr(ADDR_CMD, 32'h0000_0001);
    cyc(40);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[4], 1'b0)
    `CHK(n_scan - k, 0)
    wr(ADDR_CMD, 32'h0000_0002);
    wait_bit(0, 1'b1);
    ext_lvl[9] <= 1'b0;
    $display("test scan gate done");
    cyc(1);
    ext_lvl[4] <= 1'b1;
    setup(32'h0000_0038, 32'h0043_F4FF, 16'h0001);
    k = n_scan;
    pulse(3);
    wr(ADDR_CMD, 32'h0000_0001);
    ext_lvl[4] <= 1'b0;
    cyc(6);
    ext_lvl[4] <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK(rd[5:4], 2'b10)
    pulse(3);
    ext_lvl[4] <= 1'b0;
    wait_bit(0, 1'b1);
    `CHK(n_scan - k, 1)
    `CHK(w7, 2 * (3 + 1))
    $display("test external scan done");
    final_report();
  end
  initial begin
    cyc(60000);
    fails++;
    final_report();
  end
endmodule : acquisition_trigger_sequencer_tb
`default_nettype wire
